// ---- hw/fsp_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Pointer is high byte over low byte.
// - Low pointer bits word, high bits page.
// - Address latched when an operation starts.
// - Lock setting ignores the pointer.
// - Program reads use pointer bit zero.
// - Erase code plus store erases page.
// - Halt CPU for halting-section targets.
// - Load code stores data word to buffer.
// - Buffer clears on write, reenable, reset.
// - EEPROM write drops loaded buffer data.
// - Write code programs buffer into page.
// - Interrupt asserted while enable bit clear.
// - Erase/write blocks section, sets busy.
// - Busy holds until reenable is written.
// - Lock set programs bits where cleared.
// - Lock set neither halts nor blocks.
// - Command auto-clears after four idle cycles.
// - EEPROM write refuses programming commands.
module fsp_seq (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Classic bus slave.
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [fsp_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // CPU core side.
   input wire logic [7:0] pointer_high_byte_in,
   input wire logic [7:0] pointer_low_byte_in,
   input wire logic [7:0] data_low_reg_in,
   input wire logic [7:0] data_high_reg_in,
   input wire logic spm_strobe_in,
   input wire logic load_program_instruction_in,
   output logic [7:0] lpm_byte_out,
   output logic lpm_valid_out,
   output logic cpu_halt_out,
   output logic irq_out,
   // EEPROM controller status, same clock.
   input wire logic eeprom_busy_in,
   input wire logic eeprom_write_in,
   // Flash array side.
   output logic [fsp_pkg::PTR_W-2:0] flash_rd_addr_out,
   input wire logic [15:0] flash_rd_word_in,
   output logic rww_read_block_out,
   output logic flash_start_out,
   output logic [1:0] flash_op_out,
   output logic [fsp_pkg::PAGE_W-1:0] flash_page_out,
   output logic [fsp_pkg::LOCK_W-1:0] lock_bits_out,
   input wire logic flash_done_in,
   input wire logic [fsp_pkg::WORD_W-1:0] buf_rd_idx_in,
   output logic [15:0] buf_rd_word_out
);
   import fsp_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      fsp_state_t state;
      logic irq_en;
      logic [3:0] cmd;
      logic self_program_enable_bit;
      logic sect_busy;
      logic [PAGE_W-1:0] page;
      logic [LOCK_W-1:0] lock;
      logic halt;
      logic block;
      logic start;
      logic ack;
      logic [31:0] rdata;
      logic [7:0] lpm_byte;
      logic lpm_valid;
   } fsp_seq_st_t;

   fsp_seq_st_t q_r;
   fsp_seq_st_t q_nxt;

   logic [PTR_W-1:0] ptr;
   logic [PAGE_W-1:0] ptr_page;
   logic [WORD_W-1:0] ptr_word;
   logic ptr_halting;
   logic [4:0] code;
   logic [7:0] ctrl_byte;
   logic wb_req;
   logic wb_fire;
   logic wr_ctrl;
   logic arm_pulse;
   logic arm_expired;
   logic store_ok;
   logic op_done;
   logic buf_wr;
   logic buf_clear;
   logic buf_loaded;

   // ************************************************************
   // Address decode of the pointer
   // ************************************************************
   // The pointer is the high byte above the low byte.
   assign ptr = {pointer_high_byte_in, pointer_low_byte_in};
   // Word within page from the low bits, page from the high bits.
   assign ptr_word = ptr[PAGE_LSB-1:WORD_LSB];
   assign ptr_page = ptr[PTR_W-1:PAGE_LSB];
   assign ptr_halting = (ptr_page >= HALT_FIRST_PAGE);
   assign flash_rd_addr_out = ptr[PTR_W-1:WORD_LSB];

   assign code = {q_r.cmd, q_r.self_program_enable_bit};
   assign ctrl_byte = {q_r.irq_en, q_r.sect_busy, 1'b0, q_r.cmd, q_r.self_program_enable_bit};

   // ************************************************************
   // Bus handshake and command arming
   // ************************************************************
   // Writes take effect on the edge where the master sees the ack.
   assign wb_req = wb_cyc_in & wb_stb_in;
   assign wb_fire = wb_req & q_r.ack;
   assign wr_ctrl = wb_fire & wb_we_in & wb_sel_in[0] & (wb_adr_in == OFS_CTRL);
   // A new command is refused during an EEPROM write or a running operation.
   assign arm_pulse = wr_ctrl & wb_dat_in[BIT_SELF_PROGRAM_ENABLE_BIT] & (q_r.state == ST_IDLE) & ~eeprom_busy_in;
   // An armed store is taken only when no EEPROM write is running.
   assign store_ok = spm_strobe_in & q_r.self_program_enable_bit & (q_r.state == ST_IDLE) & ~eeprom_busy_in;
   assign op_done = flash_done_in & (q_r.state != ST_IDLE);
   assign buf_wr = store_ok & (code == CODE_LOAD);

   // The buffer is cleared by a page write, by reenable, or by an EEPROM write mid-load.
   assign buf_clear = (op_done & (q_r.state == ST_WRITE))
      | (store_ok & (code == CODE_REENABLE))
      | (eeprom_write_in & buf_loaded);

   fsp_arm_timer u_arm (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .arm_in(arm_pulse),
      .hit_in(store_ok),
      .expired_out(arm_expired)
   );

   fsp_page_buf u_buf (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .wr_en_in(buf_wr),
      .wr_idx_in(ptr_word),
      .wr_word_in({data_high_reg_in, data_low_reg_in}),
      .clear_in(buf_clear),
      .rd_idx_in(buf_rd_idx_in),
      .rd_word_out(buf_rd_word_out),
      .loaded_out(buf_loaded)
   );

   // ************************************************************
   // Next-state logic
   // ************************************************************
   // One process computes every next value; the order of the ifs sets priority.
   always_comb begin
      q_nxt = q_r;
      q_nxt.start = 1'b0;
      q_nxt.lpm_valid = 1'b0;
      q_nxt.ack = wb_req & ~q_r.ack;
      if (wb_req & ~q_r.ack) begin
         unique case (wb_adr_in)
            OFS_CTRL: q_nxt.rdata = {24'h00_0000, ctrl_byte};
            OFS_STATUS: q_nxt.rdata = {20'h0_0000, q_r.page, q_r.state};
            default: q_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // Commands not followed by a store in time are withdrawn.
      if (arm_expired) begin
         q_nxt.cmd = 4'h0;
         q_nxt.self_program_enable_bit = 1'b0;
      end
      if (wr_ctrl) begin
         q_nxt.irq_en = wb_dat_in[BIT_IRQ_EN];
         if (arm_pulse) begin
            q_nxt.cmd = wb_dat_in[BIT_CMD_LSB+3:BIT_CMD_LSB];
            q_nxt.self_program_enable_bit = 1'b1;
         end
      end
      if (store_ok) begin
         q_nxt.cmd = 4'h0;
         q_nxt.self_program_enable_bit = 1'b0;
         unique case (code)
            CODE_ERASE, CODE_WRITE: begin
               // Page is latched so the pointer may be reused meanwhile.
               q_nxt.page = ptr_page;
               q_nxt.cmd = q_r.cmd;
               q_nxt.self_program_enable_bit = 1'b1;
               q_nxt.state = (code == CODE_ERASE) ? ST_ERASE : ST_WRITE;
               q_nxt.start = 1'b1;
               q_nxt.sect_busy = 1'b1;
               q_nxt.block = 1'b1;
               q_nxt.halt = ptr_halting;
            end
            CODE_LOCK: begin
               // Pointer is not looked at; only the low data byte matters.
               q_nxt.lock = data_low_reg_in[LOCK_W-1:0];
               q_nxt.cmd = q_r.cmd;
               q_nxt.self_program_enable_bit = 1'b1;
               q_nxt.state = ST_LOCK;
               q_nxt.start = 1'b1;
               q_nxt.halt = 1'b0;
               q_nxt.block = 1'b0;
            end
            CODE_REENABLE: begin
               q_nxt.sect_busy = 1'b0;
            end
            default: begin
               // Loads finish here; unknown codes only disarm.
            end
         endcase
      end
      if (op_done) begin
         q_nxt.state = ST_IDLE;
         q_nxt.cmd = 4'h0;
         q_nxt.self_program_enable_bit = 1'b0;
         q_nxt.halt = 1'b0;
         q_nxt.block = 1'b0;
      end
      // Program reads pick the byte with pointer bit zero.
      if (load_program_instruction_in) begin
         q_nxt.lpm_valid = 1'b1;
         if (q_r.block & ~ptr_halting) begin
            q_nxt.lpm_byte = BLOCKED_BYTE;
         end else begin
            q_nxt.lpm_byte = ptr[0] ? flash_rd_word_in[15:8] : flash_rd_word_in[7:0];
         end
      end
   end

   // State register.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         q_r <= '0;
         q_r.state <= ST_IDLE;
         q_r.irq_en <= CTRL_RESET[BIT_IRQ_EN];
      end else begin
         q_r <= q_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign wb_ack_out = q_r.ack;
   assign wb_dat_out = q_r.rdata;
   assign lpm_byte_out = q_r.lpm_byte;
   assign lpm_valid_out = q_r.lpm_valid;
   assign cpu_halt_out = q_r.halt;
   assign rww_read_block_out = q_r.block;
   assign flash_start_out = q_r.start;
   assign flash_page_out = q_r.page;
   assign lock_bits_out = q_r.lock;
   // Level request replaces polling of the enable bit.
   assign irq_out = q_r.irq_en & ~q_r.self_program_enable_bit;

   // Encoding toward the array: 0 erase, 1 write, 2 lock set.
   always_comb begin
      unique case (q_r.state)
         ST_WRITE: flash_op_out = 2'h1;
         ST_LOCK: flash_op_out = 2'h2;
         default: flash_op_out = 2'h0;
      endcase
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_armed;
      arm_pulse ##1 (!spm_strobe_in)[*4];
   endsequence

   sequence s_erase_go;
      store_ok && (code == CODE_ERASE);
   endsequence

   // Lock setting takes only the low data byte, whatever the pointer holds.
   sequence s_lock_go;
      store_ok && (code == CODE_LOCK);
   endsequence

   arm_timeout_a: assert property (s_armed |=> !q_r.self_program_enable_bit && (q_r.cmd == 4'h0))
      else $error("Command survived four cycles without a store.");

   erase_start_a: assert property (s_erase_go |=> flash_start_out && (q_r.state == ST_ERASE)
         && (flash_page_out == $past(ptr_page)))
      else $error("Erase did not start on the latched page.");

   page_hold_a: assert property ((q_r.state != ST_IDLE) && !flash_start_out |-> $stable(flash_page_out))
      else $error("Latched page changed during an operation.");

   lock_no_halt_a: assert property ((q_r.state == ST_LOCK) |-> !cpu_halt_out && !rww_read_block_out)
      else $error("Lock setting halted or blocked.");

   block_busy_a: assert property (rww_read_block_out |-> ctrl_byte[BIT_SECT_BUSY])
      else $error("Section blocked without busy flag.");

   busy_hold_a: assert property (op_done && q_r.sect_busy |=> q_r.sect_busy [*2])
      else $error("Busy flag dropped without reenable.");

   done_clear_a: assert property (op_done && q_r.irq_en && !wr_ctrl |=> !q_r.self_program_enable_bit && irq_out)
      else $error("Completion left enable set or no interrupt.");

   eeprom_refuse_a: assert property (eeprom_busy_in && spm_strobe_in |=> !flash_start_out)
      else $error("Store accepted during EEPROM write.");

   idle_store_a: assert property (spm_strobe_in && !q_r.self_program_enable_bit |=> !flash_start_out
         && (q_r.state == $past(q_r.state)))
      else $error("Unarmed store had an effect.");

   halt_sect_a: assert property ((s_erase_go and ptr_halting) |=> cpu_halt_out)
      else $error("CPU not halted for halting-section erase.");

   lock_latch_a: assert property (s_lock_go |=> flash_start_out && (flash_op_out == 2'h2)
         && ({2'b00, lock_bits_out} == ($past(data_low_reg_in) & 8'h3F)))
      else $error("Lock value not taken from the low data byte.");

   reenable_clear_a: assert property (store_ok && (code == CODE_REENABLE)
         |=> !q_r.sect_busy && !q_r.self_program_enable_bit)
      else $error("Reenable left the section busy.");

   // A blocked read must never hand stale array data to the core.
   read_block_a: assert property (load_program_instruction_in && rww_read_block_out && !ptr_halting
         |=> lpm_valid_out && (lpm_byte_out == BLOCKED_BYTE))
      else $error("Read of the busy section was not blocked.");

   load_done_a: assert property (store_ok && (code == CODE_LOAD) |=> !q_r.self_program_enable_bit && !flash_start_out)
      else $error("Buffer load left the command armed.");

endmodule
`default_nettype wire

// ---- hw/fsp_pkg.sv ----
package fsp_pkg;

   // ************************************************************
   // Register map (byte addresses on the classic bus)
   // ************************************************************
   localparam int ADR_W = 5;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STATUS = 5'h04;

   // ************************************************************
   // Control register fields and reset value
   // ************************************************************
   localparam int BIT_SELF_PROGRAM_ENABLE_BIT = 0;
   localparam int BIT_CMD_LSB = 1;
   localparam int BIT_SECT_BUSY = 6;
   localparam int BIT_IRQ_EN = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Command codes as {reenable, lock set, page write, page erase, enable}.
   localparam logic [4:0] CODE_LOAD = 5'h01;
   localparam logic [4:0] CODE_ERASE = 5'h03;
   localparam logic [4:0] CODE_WRITE = 5'h05;
   localparam logic [4:0] CODE_LOCK = 5'h09;
   localparam logic [4:0] CODE_REENABLE = 5'h11;

   // ************************************************************
   // Flash addressing
   // ************************************************************
   localparam int PTR_W = 16;
   localparam int WORD_LSB = 1;
   localparam int WORD_W = 5;
   localparam int PAGE_LSB = 6;
   localparam int PAGE_W = 10;
   localparam int BUF_WORDS = 32;
   localparam int LOCK_W = 6;
   localparam logic [9:0] HALT_FIRST_PAGE = 10'h1C0;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [7:0] BLOCKED_BYTE = 8'hFF;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam logic [2:0] ARM_WINDOW_CYCLES = 3'h4;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ERASE,
      ST_WRITE,
      ST_LOCK
   } fsp_state_t;

endpackage

// ---- hw/fsp_arm_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsp_arm_timer (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic arm_in,
   input wire logic hit_in,
   output logic expired_out
);
   import fsp_pkg::*;

   typedef struct packed {
      logic [2:0] count;
   } fsp_arm_st_t;

   fsp_arm_st_t q_r;
   fsp_arm_st_t q_nxt;

   // An arming write reloads the window; a taken store or expiry ends it.
   always_comb begin
      q_nxt = q_r;
      expired_out = 1'b0;
      if (arm_in) begin
         q_nxt.count = ARM_WINDOW_CYCLES;
      end else if (hit_in) begin
         q_nxt.count = 3'h0;
      end else if (q_r.count != 3'h0) begin
         q_nxt.count = q_r.count - 3'h1;
         expired_out = (q_r.count == 3'h1);
      end
   end

   // State register.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

endmodule
`default_nettype wire

// ---- hw/fsp_page_buf.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsp_page_buf (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic wr_en_in,
   input wire logic [fsp_pkg::WORD_W-1:0] wr_idx_in,
   input wire logic [15:0] wr_word_in,
   input wire logic clear_in,
   input wire logic [fsp_pkg::WORD_W-1:0] rd_idx_in,
   output logic [15:0] rd_word_out,
   output logic loaded_out
);
   import fsp_pkg::*;

   typedef struct packed {
      logic [BUF_WORDS-1:0][15:0] words;
      logic loaded;
      logic [15:0] rd_word;
   } fsp_buf_st_t;

   fsp_buf_st_t q_r;
   fsp_buf_st_t q_nxt;

   // Clearing wins over a load in the same cycle, so stale data never survives.
   always_comb begin
      q_nxt = q_r;
      q_nxt.rd_word = q_r.words[rd_idx_in];
      if (clear_in) begin
         for (int i = 0; i < BUF_WORDS; i++) begin
            q_nxt.words[i] = ERASED_WORD;
         end
         q_nxt.loaded = 1'b0;
      end else if (wr_en_in) begin
         q_nxt.words[wr_idx_in] = wr_word_in;
         q_nxt.loaded = 1'b1;
      end
   end

   // The buffer returns to the erased pattern on system reset.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         q_r <= {{BUF_WORDS{ERASED_WORD}}, 1'b0, 16'h0000};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign rd_word_out = q_r.rd_word;
   assign loaded_out = q_r.loaded;

   buf_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      clear_in |=> (q_r.words[0] == ERASED_WORD) && !loaded_out)
      else $error("Page buffer not erased after clear.");

endmodule
`default_nettype wire

// ---- tb/fsp_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
   parameter int DELAY = 20
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic [14:0] rd_addr_in,
   output logic [15:0] rd_word_out,
   output logic done_out
);
   int count_r;

   // Every word address reads a different pattern, so a wrong address shows up.
   assign rd_word_out = {1'b0, rd_addr_in} ^ 16'hA5C3;

   // The array stays busy for a fixed time after a start, then pulses done once.
   always_ff @(posedge sys_clk_in) begin
      done_out <= 1'b0;
      if (rst_in) begin
         count_r <= 0;
      end else if (start_in) begin
         count_r <= DELAY;
      end else if (count_r > 0) begin
         count_r <= count_r - 1;
         done_out <= (count_r == 1);
      end
   end
endmodule
`default_nettype wire

// ---- tb/test_flash_self_program_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_flash_self_program_sequencer;
   import fsp_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [7:0] ph = 8'h00, pl = 8'h00, dl = 8'h00, dh = 8'h00;
   logic spm = 1'b0, load_program_instruction = 1'b0, ee_busy = 1'b0, ee_wr = 1'b0;
   logic [4:0] bidx = 5'h00;
   logic [31:0] rdat, q;
   logic ack, lpm_valid, halt, irq, block, start, done;
   logic [7:0] lpm_byte;
   logic [14:0] raddr;
   logic [15:0] rword, bword;
   logic [1:0] op;
   logic [9:0] page;
   logic [5:0] lockb;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;

   fsp_seq u_fsp_seq (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_cyc_in(req), .wb_stb_in(req),
      .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
      .wb_ack_out(ack), .pointer_high_byte_in(ph), .pointer_low_byte_in(pl), .data_low_reg_in(dl),
      .data_high_reg_in(dh), .spm_strobe_in(spm), .load_program_instruction_in(load_program_instruction),
      .lpm_byte_out(lpm_byte), .lpm_valid_out(lpm_valid), .cpu_halt_out(halt), .irq_out(irq),
      .eeprom_busy_in(ee_busy), .eeprom_write_in(ee_wr), .flash_rd_addr_out(raddr),
      .flash_rd_word_in(rword), .rww_read_block_out(block), .flash_start_out(start),
      .flash_op_out(op), .flash_page_out(page), .lock_bits_out(lockb), .flash_done_in(done),
      .buf_rd_idx_in(bidx), .buf_rd_word_out(bword));

   fsp_flash_model #(.DELAY(20)) u_fsp_flash_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .start_in(start), .rd_addr_in(raddr), .rd_word_out(rword), .done_out(done));

   // ***************************************************
   // Clock and hang guard
   // ***************************************************
   always #25 sys_clk_in = ~sys_clk_in;

   // The run needs under two thousand cycles, so this ceiling only trips on a hang.
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         stop_test();
      end
   end

   // ***************************************************
   // Shared tasks
   // ***************************************************
   task automatic stop_test();
      $display("errors=%0d comparisons=%0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One classic bus cycle; the request is held until ack is seen at an edge.
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge sys_clk_in); while (ack !== 1'b1);
      q = rdat;
      req <= 1'b0;
   endtask

   // Arms a command with the interrupt enabled and stores one cycle after the ack.
   // It returns while the one-cycle start pulse of that store still stands.
   task automatic cmd(input logic [4:0] code, input logic [15:0] ptr, input logic [15:0] d);
      wb(1'b1, OFS_CTRL, {24'h00_0000, 3'b100, code});
      {ph, pl} <= ptr;
      {dh, dl} <= d;
      spm <= 1'b1;
      @(posedge sys_clk_in);
      spm <= 1'b0;
      @(negedge sys_clk_in);
   endtask

   function automatic logic [7:0] byte_of(input logic [15:0] ptr);
      logic [15:0] w;
      w = {1'b0, ptr[15:1]} ^ 16'hA5C3;
      return ptr[0] ? w[15:8] : w[7:0];
   endfunction

   task automatic rdp(input logic [15:0] ptr, input logic [7:0] exp);
      @(posedge sys_clk_in);
      {ph, pl} <= ptr;
      load_program_instruction <= 1'b1;
      @(posedge sys_clk_in);
      load_program_instruction <= 1'b0;
      @(negedge sys_clk_in);
      chk(lpm_valid, 1'b1);
      chk(lpm_byte, exp);
   endtask

   task automatic bchk(input logic [4:0] idx, input logic [15:0] exp);
      @(posedge sys_clk_in);
      bidx <= idx;
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      chk(bword, exp);
   endtask

   // Waits for the array to finish, then lets the sequencer react to it.
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 200) begin
         @(negedge sys_clk_in);
         n++;
      end
      chk(done, 1'b1);
      @(negedge sys_clk_in);
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_reset();
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk(q, {24'h00_0000, CTRL_RESET});
      wb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      wb(1'b1, 5'h08, 32'hFFFF_FFFF);
      wb(1'b0, 5'h08, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      chk({irq, halt, block}, 3'b000);
      bchk(5'h00, ERASED_WORD);
      $display("test reset done");
   endtask

   task automatic t_page();
      cmd(CODE_LOAD, 16'h0144, 16'h1234);
      cmd(CODE_LOAD, 16'h017F, 16'hBEEF);
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk(q[0], 1'b0);
      bchk(5'h02, 16'h1234);
      bchk(5'h1F, 16'hBEEF);
      cmd(CODE_ERASE, 16'h0155, 16'hAAAA);
      chk(start, 1'b1);
      chk(op, 2'h0);
      chk(page, 10'h005);
      chk(block, 1'b1);
      chk(halt, 1'b0);
      chk(irq, 1'b0);
      rdp(16'h7001, byte_of(16'h7001));
      rdp(16'h0145, BLOCKED_BYTE);
      chk(page, 10'h005);
      wb(1'b0, OFS_STATUS, 32'h0000_0000);
      chk(q, 32'h0000_0015);
      wait_done();
      chk(block, 1'b0);
      chk(irq, 1'b1);
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk(q[7:0] & 8'h41, 8'h40);
      bchk(5'h02, 16'h1234);
      cmd(CODE_WRITE, 16'h0140, 16'h5555);
      chk(op, 2'h1);
      chk(page, 10'h005);
      wait_done();
      bchk(5'h02, ERASED_WORD);
      cmd(CODE_REENABLE, 16'h0000, 16'h0000);
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk(q[6], 1'b0);
      rdp(16'h0144, byte_of(16'h0144));
      $display("test page done");
   endtask

   task automatic t_halt();
      cmd(CODE_ERASE, 16'h7000, 16'h0000);
      chk(halt, 1'b1);
      chk(block, 1'b1);
      wait_done();
      chk(halt, 1'b0);
      cmd(CODE_REENABLE, 16'h0000, 16'h0000);
      $display("test halt done");
   endtask

   task automatic t_lock();
      cmd(CODE_LOCK, 16'h0001, 16'h00C5);
      chk(op, 2'h2);
      chk(lockb, 6'h05);
      chk({halt, block}, 2'b00);
      rdp(16'h0144, byte_of(16'h0144));
      wait_done();
      chk(irq, 1'b1);
      cmd(CODE_LOCK, 16'hFFFF, 16'h00FA);
      chk(lockb, 6'h3A);
      wait_done();
      $display("test lock done");
   endtask

   task automatic t_refuse();
      // A store one cycle after the window finds the command already gone.
      wb(1'b1, OFS_CTRL, {24'h00_0000, 3'b100, CODE_ERASE});
      repeat (4) @(posedge sys_clk_in);
      spm <= 1'b1;
      @(posedge sys_clk_in);
      spm <= 1'b0;
      repeat (2) @(negedge sys_clk_in);
      chk(start, 1'b0);
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk(q[4:0], 5'h00);
      @(posedge sys_clk_in);
      ee_busy <= 1'b1;
      cmd(CODE_ERASE, 16'h0140, 16'h0000);
      chk(start, 1'b0);
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      chk(q[0], 1'b0);
      ee_busy <= 1'b0;
      cmd(CODE_LOAD, 16'h0108, 16'h4321);
      bchk(5'h04, 16'h4321);
      @(posedge sys_clk_in);
      ee_wr <= 1'b1;
      @(posedge sys_clk_in);
      ee_wr <= 1'b0;
      bchk(5'h04, ERASED_WORD);
      cmd(CODE_LOAD, 16'h0108, 16'h4321);
      cmd(CODE_REENABLE, 16'h0000, 16'h0000);
      bchk(5'h04, ERASED_WORD);
      $display("test refuse done");
   endtask

   // Reset for ten cycles, then run every scenario in turn.
   initial begin
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_page();
      t_halt();
      t_lock();
      t_refuse();
      stop_test();
   end
endmodule
`default_nettype wire
